// *** core/tlv_pkg.sv ***
// shared constants for the three-level vectored interrupt controller
// assumes a single system clock and a synchronous active-low reset
package tlv_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_SRC = 28;
  localparam int NUM_VEC = 10;
  localparam int ADDR_W = 17;

  // ----------------------------------------
  // priority levels, ordered by urgency
  // ----------------------------------------
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_TOP  = 2'b11
  } tlv_level_t;

  // vectors that may take the top level instead of high
  localparam logic [3:0] TOP_CAPABLE_LAST = 4'h1;

  // ----------------------------------------
  // vector addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] VEC_ADDR [NUM_VEC] = '{
    17'h0_0003, 17'h0_000B, 17'h0_0013, 17'h0_001B, 17'h0_0023,
    17'h0_002B, 17'h0_0033, 17'h0_003B, 17'h0_0043, 17'h0_004B
  };

  // ----------------------------------------
  // source index to vector index
  // ----------------------------------------
  localparam logic [3:0] SRC_VEC [NUM_SRC] = '{
    4'h0, 4'h1,                   // pin a, pin b
    4'h2, 4'h2, 4'h2,             // pin c, timer0 low, ext e
    4'h3, 4'h3, 4'h3,             // pin d, base timer, ext f
    4'h4, 4'h4,                   // timer0 high, ext g
    4'h5, 4'h5, 4'h5,             // timer1 low/high, ext h
    4'h6, 4'h6, 4'h6,             // sync serial, timer8 low/high
    4'h7, 4'h7,                   // async/sync serial, third serial
    4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, // converter, detector, t6, t7, pwm a/b
    4'h9, 4'h9, 4'h9, 4'h9        // display, port zero, t4, t5
  };

  // option-dependent sources
  localparam int SRC_THIRD_SERIAL = 17;
  localparam int SRC_PWM_A = 22;
  localparam int SRC_PWM_B = 23;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] INSERV_RST = 3'h0;
  localparam logic [3:0] VEC_IDX_RST = 4'h0;

endpackage

// *** core/tlv_src_latch.sv ***
// one pending flag for one interrupt source
// assumes set and clear are synchronous single-cycle or level inputs
`timescale 1ns/1ns
`default_nettype none
module tlv_src_latch
  import tlv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic pend_nxt_o,
  output logic pend_o
);

  logic pend_r;

  // set beats a clear in the same cycle so no event is dropped
  assign pend_nxt_o = set_i | (pend_r & ~clr_i);
  assign pend_o = pend_r;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt_o;
    end
  end

endmodule
`default_nettype wire

// *** core/tlv_intc.sv ***
// three-level vectored interrupt controller: pending flags, level
// arbitration, nesting of in-service levels
// assumes the core pulses accept while a request is shown and pulses
// return at the end of each handler
`timescale 1ns/1ns
`default_nettype none

// Contract
// - three nested levels: top over high over low
// - refuse requests not above in-service level
// - simultaneous requests: highest level wins
// - equal level: smallest vector address wins
// - pin a on 00003H, top or low
// - pin b on 0000BH, top or low
// - 00013H: pin c, timer0 low, ext e
// - 0001BH: pin d, base timer, ext f
// - 00023H: timer0 high, ext g
// - 0002BH: timer1 both halves, ext h
// - 00033H: sync serial, timer8 both halves
// - 0003BH: async serial, third serial in option b
// - 00043H: converter, detector, t6, t7, pwm in a
// - 0004BH: display, port zero, t4, t5
// - 27 sources option a, 26 option b
module tlv_intc
  import tlv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_option_b_i,
  input wire logic ext_pin_irq_a_i,
  input wire logic ext_pin_irq_b_i,
  input wire logic ext_pin_irq_c_i,
  input wire logic timer_zero_low_event_i,
  input wire logic ext_irq_e_i,
  input wire logic ext_pin_irq_d_i,
  input wire logic base_timer_event_i,
  input wire logic ext_irq_f_i,
  input wire logic timer_zero_high_event_i,
  input wire logic ext_irq_g_i,
  input wire logic timer_one_low_event_i,
  input wire logic timer_one_high_event_i,
  input wire logic ext_irq_h_i,
  input wire logic first_sync_serial_port_i,
  input wire logic timer_eight_low_event_i,
  input wire logic timer_eight_high_event_i,
  input wire logic async_sync_serial_port_i,
  input wire logic third_serial_port_i,
  input wire logic converter_event_i,
  input wire logic small_signal_detector_i,
  input wire logic timer_six_event_i,
  input wire logic timer_seven_event_i,
  input wire logic wide_pulse_channel_a_i,
  input wire logic wide_pulse_channel_b_i,
  input wire logic display_event_i,
  input wire logic port_zero_event_i,
  input wire logic timer_four_event_i,
  input wire logic timer_five_event_i,
  input wire logic [NUM_SRC-1:0] src_enable_i,
  input wire logic [NUM_SRC-1:0] src_clear_i,
  input wire logic [NUM_VEC-1:0] vec_level_upper_i,
  input wire logic irq_accept_i,
  input wire logic irq_return_i,
  output logic irq_req_o,
  output logic [ADDR_W-1:0] irq_vec_addr_o,
  output logic [1:0] irq_level_o,
  output logic [1:0] in_service_level_o,
  output logic [NUM_SRC-1:0] pending_o
);

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  // upper choice means top for the two pin vectors, high for the rest
  function automatic tlv_level_t vec_level(input logic [3:0] v, input logic upper);
    tlv_level_t l;
    if (!upper) begin
      l = LVL_LOW;
    end else if (v <= TOP_CAPABLE_LAST) begin
      l = LVL_TOP;
    end else begin
      l = LVL_HIGH;
    end
    return l;
  endfunction

  // most urgent level still in service; mask bit n stands for level n+1
  function automatic tlv_level_t top_of(input logic [2:0] m);
    tlv_level_t l;
    if (m[2]) begin
      l = LVL_TOP;
    end else if (m[1]) begin
      l = LVL_HIGH;
    end else if (m[0]) begin
      l = LVL_LOW;
    end else begin
      l = LVL_NONE;
    end
    return l;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic opt_b_r;
  logic [2:0] inserv_r;
  logic [2:0] inserv_nxt;
  logic [3:0] vec_idx_r;
  logic [3:0] win_idx;
  logic win_valid;
  tlv_level_t win_lvl;
  tlv_level_t cur_nxt;
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_present;
  logic [NUM_SRC-1:0] src_clr;
  logic [NUM_SRC-1:0] pend_nxt;
  logic [NUM_VEC-1:0] vec_req;

  // source order follows the vector table
  assign src_raw = {
    timer_five_event_i, timer_four_event_i, port_zero_event_i, display_event_i,
    wide_pulse_channel_b_i, wide_pulse_channel_a_i, timer_seven_event_i,
    timer_six_event_i, small_signal_detector_i, converter_event_i,
    third_serial_port_i, async_sync_serial_port_i,
    timer_eight_high_event_i, timer_eight_low_event_i, first_sync_serial_port_i,
    ext_irq_h_i, timer_one_high_event_i, timer_one_low_event_i,
    ext_irq_g_i, timer_zero_high_event_i,
    ext_irq_f_i, base_timer_event_i, ext_pin_irq_d_i,
    ext_irq_e_i, timer_zero_low_event_i, ext_pin_irq_c_i,
    ext_pin_irq_b_i, ext_pin_irq_a_i
  };

  // ----------------------------------------
  // configuration option
  // ----------------------------------------
  // caught while reset is held; treated as a strap afterwards
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      opt_b_r <= cfg_option_b_i;
    end
  end

  always_comb begin
    src_present = '1;
    if (opt_b_r) begin
      src_present[SRC_PWM_A] = 1'b0;
      src_present[SRC_PWM_B] = 1'b0;
    end else begin
      src_present[SRC_THIRD_SERIAL] = 1'b0;
    end
  end

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  // accept clears every flag of the granted vector; the handler polls
  // its peripherals to find which of the shared sources fired
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      assign src_clr[gi] = src_clear_i[gi] |
                           (irq_accept_i & irq_req_o & (SRC_VEC[gi] == vec_idx_r));
      tlv_src_latch u_latch (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(src_raw[gi] & src_present[gi]),
        .clr_i(src_clr[gi]),
        .pend_nxt_o(pend_nxt[gi]),
        .pend_o()
      );
    end
  endgenerate

  // ----------------------------------------
  // in-service nesting
  // ----------------------------------------
  // return drops the most urgent level, which exposes the one below
  always_comb begin
    inserv_nxt = inserv_r;
    if (irq_return_i) begin
      if (inserv_r[2]) begin
        inserv_nxt[2] = 1'b0;
      end else if (inserv_r[1]) begin
        inserv_nxt[1] = 1'b0;
      end else begin
        inserv_nxt[0] = 1'b0;
      end
    end
    if (irq_accept_i && irq_req_o) begin
      inserv_nxt[irq_level_o - 2'd1] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      inserv_r <= INSERV_RST;
    end else begin
      inserv_r <= inserv_nxt;
    end
  end

  assign cur_nxt = top_of(inserv_nxt);

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  // built on the next-state flags so an accepted vector never shows twice
  always_comb begin
    vec_req = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (pend_nxt[s] && src_enable_i[s]) begin
        vec_req[SRC_VEC[s]] = 1'b1;
      end
    end
  end

  always_comb begin
    tlv_level_t l;
    l = LVL_NONE;
    win_valid = 1'b0;
    win_idx = VEC_IDX_RST;
    win_lvl = LVL_NONE;
    // walking downward with >= leaves the smallest address on a tie
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      l = vec_level(4'(v), vec_level_upper_i[v]);
      if (vec_req[v] && (l > cur_nxt) && (l >= win_lvl)) begin
        win_valid = 1'b1;
        win_idx = 4'(v);
        win_lvl = l;
      end
    end
  end

  // ----------------------------------------
  // outputs to the core
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_req_o <= 1'b0;
      vec_idx_r <= VEC_IDX_RST;
      irq_vec_addr_o <= VEC_ADDR[0];
      irq_level_o <= LVL_NONE;
    end else begin
      irq_req_o <= win_valid;
      vec_idx_r <= win_idx;
      irq_vec_addr_o <= VEC_ADDR[win_idx];
      irq_level_o <= win_valid ? win_lvl : LVL_NONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      in_service_level_o <= LVL_NONE;
      pending_o <= '0;
    end else begin
      in_service_level_o <= cur_nxt;
      pending_o <= pend_nxt;
    end
  end

endmodule
`default_nettype wire

// *** test/tlv_intc_assertions.sv ***
// port checker for the vectored interrupt controller
// assumes one clock and a synchronous active-low reset; bound onto tlv_intc
`timescale 1ns/1ns
`default_nettype none
module tlv_intc_checker
  import tlv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic irq_accept_i,
  input wire logic irq_return_i,
  input wire logic [NUM_VEC-1:0] vec_level_upper_i,
  input wire logic [NUM_SRC-1:0] src_clear_i,
  input wire logic irq_req_o,
  input wire logic [ADDR_W-1:0] irq_vec_addr_o,
  input wire logic [1:0] irq_level_o,
  input wire logic [1:0] in_service_level_o,
  input wire logic [NUM_SRC-1:0] pending_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic tk;
  assign tk = irq_accept_i && irq_req_o;
  // ---------------
  // checks
  // ---------------
  a_req_above: assert property (irq_req_o |-> irq_level_o > in_service_level_o)
    else $error("request not above in-service level");
  a_accept_rise: assert property (tk |=> in_service_level_o == $past(irq_level_o))
    else $error("accepted level not in service");
  a_accept_next: assert property (tk |=>
    !irq_req_o || irq_level_o > $past(irq_level_o))
    else $error("request after accept not more urgent");
  a_ret_lower: assert property (
    irq_return_i && !irq_accept_i && in_service_level_o != 2'h0
    |=> in_service_level_o < $past(in_service_level_o))
    else $error("return did not lower level");
  a_hold_level: assert property (
    !irq_return_i |=> in_service_level_o >= $past(in_service_level_o))
    else $error("level dropped without return");
  a_top_vecs: assert property (irq_level_o == 2'h3 |-> irq_vec_addr_o <= 17'h0_000B)
    else $error("top level on a high-only vector");
  a_pin_a_lvl: assert property (irq_req_o && irq_vec_addr_o == 17'h0_0003
    |-> irq_level_o == ($past(vec_level_upper_i[0]) ? 2'h3 : 2'h1))
    else $error("pin a level wrong");
  a_pend_hold: assert property (!irq_accept_i && src_clear_i == '0
    |=> (pending_o & $past(pending_o)) == $past(pending_o))
    else $error("pending flag lost");
  a_addr_grid: assert property (irq_req_o |-> irq_vec_addr_o[2:0] == 3'h3
    && irq_vec_addr_o <= 17'h0_004B)
    else $error("vector address off grid");
  c_top: cover property (in_service_level_o == 2'h3);
  c_take: cover property (tk);
  c_ret: cover property (irq_return_i && in_service_level_o != 2'h0);
endmodule
bind tlv_intc tlv_intc_checker u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .irq_accept_i(irq_accept_i), .irq_return_i(irq_return_i), .src_clear_i(src_clear_i),
  .vec_level_upper_i(vec_level_upper_i), .irq_req_o(irq_req_o), .irq_level_o(irq_level_o),
  .irq_vec_addr_o(irq_vec_addr_o), .in_service_level_o(in_service_level_o),
  .pending_o(pending_o));
`default_nettype wire

// *** test/tlv_cpu_model.sv ***
// core-side model: takes the shown vector and ends handlers on command
// assumes the bench calls take and leave; drives 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module tlv_cpu_model (
  input wire logic core_clk_i,
  input wire logic irq_req_i,
  output logic accept_o,
  output logic return_o
);
  initial begin
    accept_o = 1'h0;
    return_o = 1'h0;
  end
  // lat models a slow core; only a shown request is ever taken
  task automatic take(input int lat);
    repeat (lat) @(posedge core_clk_i);
    @(posedge core_clk_i);
    #1;
    if (irq_req_i) begin
      accept_o = 1'h1;
      @(posedge core_clk_i);
      #1 accept_o = 1'h0;
    end
  endtask
  task automatic leave();
    @(posedge core_clk_i);
    #1 return_o = 1'h1;
    @(posedge core_clk_i);
    #1 return_o = 1'h0;
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the vectored interrupt controller
// assumes the core model in tlv_cpu_model; 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import tlv_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic opt_b = 1'h0;
  logic [27:0] src = '0;
  logic [27:0] en = '1;
  logic [27:0] clr = '0;
  logic [9:0] lv = '0;
  logic acc, ret, req;
  logic [16:0] addr;
  logic [1:0] lvl, isl;
  logic [27:0] pend;
  logic [19:0] st;
  int failures = 0;
  int num_checks = 0;
  int vt [28] = '{0, 1, 2, 2, 2, 3, 3, 3, 4, 4, 5, 5, 5, 6,
                  6, 6, 7, 7, 8, 8, 8, 8, 8, 8, 9, 9, 9, 9};
  assign st = {req, lvl, addr};
  always #50 core_clk = ~core_clk;
  tlv_intc u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .cfg_option_b_i(opt_b),
    .ext_pin_irq_a_i(src[0]), .ext_pin_irq_b_i(src[1]), .ext_pin_irq_c_i(src[2]),
    .timer_zero_low_event_i(src[3]), .ext_irq_e_i(src[4]), .ext_pin_irq_d_i(src[5]),
    .base_timer_event_i(src[6]), .ext_irq_f_i(src[7]), .timer_zero_high_event_i(src[8]),
    .ext_irq_g_i(src[9]), .timer_one_low_event_i(src[10]), .timer_one_high_event_i(src[11]),
    .ext_irq_h_i(src[12]), .first_sync_serial_port_i(src[13]), .timer_eight_low_event_i(src[14]),
    .timer_eight_high_event_i(src[15]), .async_sync_serial_port_i(src[16]),
    .third_serial_port_i(src[17]), .converter_event_i(src[18]), .small_signal_detector_i(src[19]),
    .timer_six_event_i(src[20]), .timer_seven_event_i(src[21]), .wide_pulse_channel_a_i(src[22]),
    .wide_pulse_channel_b_i(src[23]), .display_event_i(src[24]), .port_zero_event_i(src[25]),
    .timer_four_event_i(src[26]), .timer_five_event_i(src[27]), .src_enable_i(en),
    .src_clear_i(clr), .vec_level_upper_i(lv), .irq_accept_i(acc), .irq_return_i(ret),
    .irq_req_o(req), .irq_vec_addr_o(addr), .irq_level_o(lvl), .in_service_level_o(isl),
    .pending_o(pend));
  tlv_cpu_model u_cpu (.core_clk_i(core_clk), .irq_req_i(req), .accept_o(acc), .return_o(ret));
  // ---------------
  // helpers
  // ---------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [19:0] want(input logic r, input logic [1:0] l, input int v);
    return {r, l, r ? 17'h0_0003 + 17'(8 * v) : 17'h0_0003};
  endfunction
  task automatic fire(input logic [27:0] m);
    @(posedge core_clk);
    #1 src = m;
    @(posedge core_clk);
    #1 src = '0;
  endtask
  task automatic wipe();
    @(posedge core_clk);
    #1 clr = '1;
    @(posedge core_clk);
    #1 clr = '0;
  endtask
  task automatic do_reset(input logic b);
    rst_n = 1'h0;
    opt_b = b;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'h1;
  endtask
  // ---------------
  // scenarios
  // ---------------
  task automatic t_map();
    chk(st, want(1'h0, 2'h0, 0));
    for (int k = 0; k < 28; k++) begin
      fire(28'h000_0001 << k);
      chk(pend, (k == 17) ? 28'h000_0000 : 28'h000_0001 << k);
      chk(st, want(k != 17, {1'h0, k != 17}, vt[k]));
      wipe();
    end
  endtask
  task automatic t_optb();
    do_reset(1'h1);
    fire(28'h0C2_0000);
    chk(pend, 28'h002_0000);
    chk(st, want(1'h1, 2'h1, 7));
    wipe();
    do_reset(1'h0);
  endtask
  task automatic t_prio();
    lv = 10'h060;
    fire(28'h000_2421);
    chk(st, want(1'h1, 2'h2, 5));
    u_cpu.take(3);
    chk({isl, st}, {2'h2, want(1'h0, 2'h0, 0)});
    u_cpu.leave();
    chk({isl, st}, {2'h0, want(1'h1, 2'h2, 6)});
    u_cpu.take(0);
    u_cpu.leave();
    chk(st, want(1'h1, 2'h1, 0));
    wipe();
  endtask
  task automatic t_nest();
    lv = 10'h006;
    fire(28'h000_0001);
    u_cpu.take(0);
    chk(isl, 2'h1);
    fire(28'h000_001C);
    chk(st, want(1'h1, 2'h2, 2));
    u_cpu.take(0);
    chk({isl, pend[4:2]}, {2'h2, 3'h0});
    fire(28'h000_0003);
    chk(st, want(1'h1, 2'h3, 1));
    u_cpu.take(1);
    chk({isl, st}, {2'h3, want(1'h0, 2'h0, 0)});
    u_cpu.leave();
    chk(isl, 2'h2);
    u_cpu.leave();
    u_cpu.leave();
    chk({isl, st}, {2'h0, want(1'h1, 2'h1, 0)});
    wipe();
    lv = 10'h001;
    fire(28'h000_0001);
    chk(st, want(1'h1, 2'h3, 0));
    wipe();
  endtask
  // disabled source still pends; set wins over a clear in the same cycle
  task automatic t_gate();
    lv = 10'h000;
    en = 28'hFFF_FFFD;
    fire(28'h000_0002);
    chk({pend[1], st}, {1'h1, want(1'h0, 2'h0, 0)});
    en = '1;
    @(posedge core_clk);
    #1;
    chk(st, want(1'h1, 2'h1, 1));
    src = 28'h000_0002;
    clr = 28'h000_0002;
    @(posedge core_clk);
    #1 src = '0;
    chk(pend, 28'h000_0002);
    @(posedge core_clk);
    #1 clr = '0;
    chk(pend, 28'h000_0000);
    chk(st, want(1'h0, 2'h0, 0));
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'h0);
    t_map();
    t_optb();
    t_prio();
    t_nest();
    t_gate();
    close_out();
  end
  // whole run is under two hundred cycles; this cuts a hang
  initial begin
    #1_000_000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
